/* core/essc_regs.sv */
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Extended speed status and control register bank on Avalon-MM.
////////////////////////////////////////////////////////////////////////////////

// Operation
// - Optional capability register all reserved, reads zero.
// - Bank exists only when support flag set.
// - Status reports negotiated rate, seven bits.
// - Rate resets to zero meaning inactive.
// - Calibration done set when calibration finishes.
// - Writing one to request starts calibration.
// - Calibrate only in non-D0 idle L1.
// - Calibration request always reads zero.
// - Low target rate field bits 6:0.
// - High target rate field bits 14:8.
// - Controls sticky while compliance flag set.
// - Target rates reset to no speed.
// - Status upper bits read zero.
module essc_regs (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        sticky_nrst,          // Reset that clears the sticky fields.
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,          // Byte address.
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // Physical layer and link state machine side, asynchronous.
  input  wire logic        ext_speed_support_flag,  // Strap: mode supported.
  input  wire logic [6:0]  negotiated_rate_in,      // Rate from the link.
  input  wire logic        link_low_power,          // Link in a non-D0 state.
  input  wire logic        link_in_l1,              // Link idle in L1.
  input  wire logic        phy_cal_finished,        // Physical layer done.
  output logic             phy_cal_start,           // Calibration start pulse.
  output logic [6:0]       target_rate_low,
  output logic [6:0]       target_rate_high
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [1:0] sy_sup;     // Support strap synchroniser.
    logic [1:0] sy_lp;      // Low power synchroniser.
    logic [1:0] sy_l1;      // L1 synchroniser.
    logic [1:0] sy_done;    // Physical done synchroniser.
    logic [6:0] rate_s1;    // Rate synchroniser first stage.
    logic [6:0] rate_s2;    // Rate synchroniser second stage.
    logic [6:0] rate;       // Negotiated rate as shown.
    logic       support;    // Captured support flag.
    logic       compl;      // Compliance test flag.
    logic [1:0] wait_cnt;   // Access wait counter.
    logic       busy;       // Access in progress.
    logic       start;      // Calibration request pulse.
    logic [31:0] rdata;     // Read data register.
    logic [1:0] resp;       // Response code register.
  } essc_regs_s;

  essc_regs_s s_q;
  essc_regs_s s_d;

  // Sticky fields live apart so that a plain reset spares them under test.
  logic [6:0] rate_lo_q;
  logic [6:0] rate_lo_d;
  logic [6:0] rate_hi_q;
  logic [6:0] rate_hi_d;

  logic       cal_done;      // Done flag from the sequencer.
  logic       acc_done;      // The access completes this cycle.

  // Builds the status word; upper bits stay zero.
  function automatic logic [31:0] status_word(input logic [6:0] r, input logic d);
    status_word = essc_pkg::RSVD_VALUE;
    status_word[essc_pkg::RATE_W-1:0] = r;
    status_word[essc_pkg::CAL_DONE_BIT] = d;
  endfunction : status_word

  // Merges write data into a seven bit field under byte enables.
  function automatic logic [6:0] merge7(input logic [6:0] old, input logic [6:0] nw,
                                        input logic en);
    merge7 = en ? nw : old;
  endfunction : merge7

  ////////////////////////////////////////////////////////////////////////////
  // Access engine.
  ////////////////////////////////////////////////////////////////////////////

  assign acc_done = s_q.busy && (s_q.wait_cnt == essc_pkg::BUS_WAIT_CYCLES);

  // Next state: synchronisers, strap capture and the register access.
  always_comb begin
    s_d         = s_q;
    rate_lo_d   = rate_lo_q;
    rate_hi_d   = rate_hi_q;
    s_d.start   = 1'b0;
    s_d.sy_sup  = {s_q.sy_sup[0], ext_speed_support_flag};
    s_d.sy_lp   = {s_q.sy_lp[0], link_low_power};
    s_d.sy_l1   = {s_q.sy_l1[0], link_in_l1};
    s_d.sy_done = {s_q.sy_done[0], phy_cal_finished};
    s_d.rate_s1 = negotiated_rate_in;
    s_d.rate_s2 = s_q.rate_s1;
    s_d.support = s_q.sy_sup[1];
    // Rate shows zero whenever the bank is absent.
    s_d.rate    = s_q.sy_sup[1] ? s_q.rate_s2 : essc_pkg::RATE_RESET;
    if (!s_q.busy) begin
      if (avs_read || avs_write) begin
        s_d.busy     = 1'b1;
        s_d.wait_cnt = 2'h0;
      end
    end else if (!acc_done) begin
      s_d.wait_cnt = s_q.wait_cnt + 2'h1;
      // Read data and response are formed one cycle before the answer.
      s_d.resp  = 2'h0;
      s_d.rdata = essc_pkg::RSVD_VALUE;
      if (!s_q.support && (avs_address != essc_pkg::OFS_SUPPORT)) begin
        // Absent bank: reads zero, writes dropped.
        s_d.rdata = essc_pkg::RSVD_VALUE;
      end else if (avs_address == essc_pkg::OFS_OPT_CAP) begin
        s_d.rdata = essc_pkg::RSVD_VALUE;
      end else if (avs_address == essc_pkg::OFS_STATUS) begin
        s_d.rdata = status_word(s_q.rate, cal_done);
      end else if (avs_address == essc_pkg::OFS_CONTROL) begin
        s_d.rdata[essc_pkg::RATE_W-1:0] = rate_lo_q;
        s_d.rdata[essc_pkg::RATE_HIGH_LSB +: essc_pkg::RATE_W] = rate_hi_q;
        s_d.rdata[essc_pkg::CAL_REQ_BIT] = 1'b0;
      end else if (avs_address == essc_pkg::OFS_SUPPORT) begin
        s_d.rdata[essc_pkg::SUPPORT_BIT] = s_q.support;
        s_d.rdata[essc_pkg::COMPL_BIT]   = s_q.compl;
      end else begin
        s_d.resp = 2'h2;  // Unmapped address answers slave error.
      end
    end else begin
      s_d.busy = 1'b0;
      if (avs_write && (s_q.resp == 2'h0)) begin
        if (avs_address == essc_pkg::OFS_CONTROL && s_q.support) begin
          // Software keeps to supported rates; no filtering here.
          rate_lo_d = merge7(rate_lo_q, avs_writedata[6:0], avs_byteenable[0]);
          rate_hi_d = merge7(rate_hi_q, avs_writedata[14:8], avs_byteenable[1]);
          s_d.start = avs_byteenable[0] && avs_writedata[essc_pkg::CAL_REQ_BIT];
        end else if (avs_address == essc_pkg::OFS_SUPPORT && avs_byteenable[0]) begin
          s_d.compl = avs_writedata[essc_pkg::COMPL_BIT];
        end
      end
    end
  end

  // Main registers; the compliance flag is itself sticky.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '{compl: s_q.compl, default: '0};
    end else begin
      s_q <= s_d;
    end
    if (!sticky_nrst) begin
      s_q.compl <= 1'b0;
    end
  end

  // Target rates: a plain reset clears them unless compliance holds them.
  always_ff @(posedge clk_sys) begin
    if (!sticky_nrst || (!nrst && !s_q.compl)) begin
      rate_lo_q <= essc_pkg::RATE_RESET;
      rate_hi_q <= essc_pkg::RATE_RESET;
    end else if (!nrst) begin
      rate_lo_q <= rate_lo_q;
      rate_hi_q <= rate_hi_q;
    end else begin
      rate_lo_q <= rate_lo_d;
      rate_hi_q <= rate_hi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer.
  ////////////////////////////////////////////////////////////////////////////

  essc_cal_seq u_cal (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .start     (s_q.start),
    .low_power (s_q.sy_lp[1]),
    .in_l1     (s_q.sy_l1[1]),
    .phy_done  (s_q.sy_done[1]),
    .phy_start (phy_cal_start),
    .done      (cal_done)
  );

  // Outputs.
  assign avs_waitrequest  = !acc_done;
  assign avs_readdata     = s_q.rdata;
  assign avs_response     = s_q.resp;
  assign target_rate_low  = rate_lo_q;
  assign target_rate_high = rate_hi_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  ////////////////////////////////////////////////////////////////////////////

  status_upper_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    acc_done && avs_address == essc_pkg::OFS_STATUS |-> avs_readdata[31:8] == 24'h0)
    else $error("status upper bits not zero");

  req_reads_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    acc_done && avs_address == essc_pkg::OFS_CONTROL |-> !avs_readdata[7])
    else $error("calibration request read as one");

  opt_cap_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    acc_done && avs_address == essc_pkg::OFS_OPT_CAP |-> avs_readdata == 32'h0)
    else $error("optional capability not zero");

  absent_bank_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !s_q.support |-> s_q.rate == 7'h00 || $past(s_q.sy_sup[1]))
    else $error("rate shown while bank absent");

  req_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    acc_done && avs_write && avs_address == essc_pkg::OFS_CONTROL && s_q.support
      && s_q.resp == 2'h0 && avs_byteenable[0] && avs_writedata[7] |=> s_q.start)
    else $error("calibration request not taken");

  rate_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    acc_done && avs_write && avs_address == essc_pkg::OFS_CONTROL && s_q.support
      && avs_byteenable[1] |=> rate_hi_q == $past(avs_writedata[14:8]))
    else $error("high rate not written");

  rate_reset_a: assert property (@(posedge clk_sys)
    !sticky_nrst |=> rate_lo_q == 7'h00 && rate_hi_q == 7'h00)
    else $error("target rates not cleared");

  sticky_hold_a: assert property (@(posedge clk_sys) disable iff (!sticky_nrst)
    !nrst && s_q.compl |=> rate_lo_q == $past(rate_lo_q))
    else $error("sticky rate lost in reset");

endmodule : essc_regs

`default_nettype wire

/* shared/essc_pkg.sv */
package essc_pkg;

  // Register byte offsets on the Avalon-MM slave (word aligned).
  localparam logic [3:0] OFS_OPT_CAP  = 4'h0;  // Optional speed capability.
  localparam logic [3:0] OFS_STATUS   = 4'h4;  // Extended speed status.
  localparam logic [3:0] OFS_CONTROL  = 4'h8;  // Extended speed control.
  localparam logic [3:0] OFS_SUPPORT  = 4'hc;  // Local support and compliance.

  // Field positions.
  localparam int RATE_W        = 7;   // Width of every rate field.
  localparam int CAL_DONE_BIT  = 7;   // Status calibration done bit.
  localparam int CAL_REQ_BIT   = 7;   // Control calibration request bit.
  localparam int RATE_HIGH_LSB = 8;   // Control target rate high field.
  localparam int SUPPORT_BIT   = 0;   // Support register: support flag.
  localparam int COMPL_BIT     = 1;   // Support register: compliance flag.

  // Reset values.
  localparam logic [6:0]  RATE_RESET = 7'h00;  // Inactive or no speed.
  localparam logic [31:0] RSVD_VALUE = 32'h0000_0000;

  // Rate encodings.
  localparam logic [6:0] RATE_2G5  = 7'h01;
  localparam logic [6:0] RATE_5G0  = 7'h02;
  localparam logic [6:0] RATE_8G0  = 7'h03;
  localparam logic [6:0] RATE_16G0 = 7'h06;
  localparam logic [6:0] RATE_20G0 = 7'h0a;
  localparam logic [6:0] RATE_25G0 = 7'h0f;

  // Wait count at which a register access answers; waitrequest stays high for this plus one cycle.
  localparam logic [1:0] BUS_WAIT_CYCLES = 2'h1;

endpackage : essc_pkg

/* core/essc_cal_seq.sv */
`timescale 1ns/1ps
`default_nettype none

// Calibration sequencer: holds a pending request until the link is parked
// in a non-D0 power state with the link state machine idle in L1.
module essc_cal_seq (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic start,       // One-cycle pulse from a written request.
  input  wire logic low_power,   // Synchronised: link in a non-D0 state.
  input  wire logic in_l1,       // Synchronised: link idle in L1.
  input  wire logic phy_done,    // Synchronised: physical layer finished.
  output logic      phy_start,   // Pulse that starts physical calibration.
  output logic      done         // Calibration done flag.
);

  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_RUN} essc_cs_e;

  typedef struct packed {
    essc_cs_e st;     // Sequencer state.
    logic     go;     // Start pulse register.
    logic     done;   // Done flag.
  } essc_cs_s;

  essc_cs_s s_q;
  essc_cs_s s_d;

  // Next state logic; a new request always restarts the sequence.
  always_comb begin
    s_d    = s_q;
    s_d.go = 1'b0;
    case (s_q.st)
      CS_WAIT: begin
        if (low_power && in_l1) begin
          s_d.go = 1'b1;
          s_d.st = CS_RUN;
        end
      end
      CS_RUN: begin
        if (phy_done) begin
          s_d.done = 1'b1;
          s_d.st   = CS_IDLE;
        end
      end
      default: begin
      end
    endcase
    if (start) begin
      // A fresh request clears done and waits again; it wins over completion.
      s_d.done = 1'b0;
      s_d.go   = 1'b0;
      s_d.st   = CS_WAIT;
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '{st: CS_IDLE, go: 1'b0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign phy_start = s_q.go;
  assign done      = s_q.done;

  // Calibration never starts outside low power L1.
  cal_gated_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(s_q.go) |-> $past(low_power) && $past(in_l1))
    else $error("calibration started outside low power L1");

  // Done is only raised by a physical layer completion.
  done_cause_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(s_q.done) |-> $past(phy_done) && $past(s_q.st == CS_RUN))
    else $error("done raised without completion");

  // Done holds until a new request.
  done_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.done && !start |=> s_q.done)
    else $error("done dropped without request");

endmodule : essc_cal_seq

`default_nettype wire

/* testbench/essc_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// Bench for the extended speed register bank, driven over Avalon-MM.
module testbench;
  logic        clk_sys;                 // System clock, 4 ns period.
  logic        nrst;                    // Main reset, active low.
  logic        sticky_nrst;             // Sticky reset, active low.
  logic [3:0]  avs_address;             // Byte address of the access.
  logic        avs_read;                // Read strobe.
  logic        avs_write;               // Write strobe.
  logic [31:0] avs_writedata;           // Write data.
  logic [3:0]  avs_byteenable;          // Lane enables.
  logic [31:0] avs_readdata;            // Read data.
  logic        avs_waitrequest;         // Slave stall.
  logic [1:0]  avs_response;            // Access status.
  logic        ext_speed_support_flag;  // Strap that enables the bank.
  logic [6:0]  negotiated_rate_in;      // Rate seen by the link.
  logic        link_low_power;          // Link parked in low power.
  logic        link_in_l1;              // Link idle in L1.
  logic        phy_cal_finished;        // Physical layer finished.
  logic        phy_cal_start;           // Calibration start pulse.
  logic [6:0]  target_rate_low;         // Low target rate output.
  logic [6:0]  target_rate_high;        // High target rate output.
  int          n_mismatch;              // Mismatches counted.
  int          checks_done;             // Comparisons made.
  int          npulse;                  // Start pulses seen.
  logic [31:0] rd;                      // Read data of the last access.
  logic [1:0]  rs;                      // Response of the last access.
  logic [6:0]  lows [3];                // Low field codes.
  logic [6:0]  highs [4];               // High field codes.
  logic [6:0]  codes [7];               // Status rate codes.

  essc_regs u_dut (.clk_sys, .nrst, .sticky_nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .ext_speed_support_flag, .negotiated_rate_in, .link_low_power, .link_in_l1,
    .phy_cal_finished, .phy_cal_start, .target_rate_low, .target_rate_high);

  //////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Compares one value; four-state so an unknown never matches.
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // One access. Starting one edge late keeps two drives out of one step.
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    // Waitrequest is sampled at the rising edge; the write lands at that edge.
    for (i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 64) begin
      n_mismatch++;
      give_verdict();
    end
    // Read data and response stand at the edge that saw waitrequest low.
    rd = avs_readdata;
    rs = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  // Reads an address and compares the word.
  task automatic rdchk(input string w, input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk(w, e, rd);
  endtask : rdchk

  // Counts start pulses over n cycles, ending just after a rising edge.
  task automatic count_start(input int n);
    npulse = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (phy_cal_start === 1'b1) npulse++;
    end
    @(posedge clk_sys);
  endtask : count_start

  // Applies nrst, and sticky_nrst too when all is set.
  task automatic do_reset(input logic all);
    @(posedge clk_sys);
    nrst        <= 1'b0;
    sticky_nrst <= !all;
    repeat (5) @(posedge clk_sys);
    nrst        <= 1'b1;
    sticky_nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  // Reset values, and writes to places that must stay zero.
  task automatic t_reset();
    rdchk("status", essc_pkg::OFS_STATUS, 32'h0000_0000);
    rdchk("control", essc_pkg::OFS_CONTROL, 32'h0000_0000);
    chk("low out", 32'h0, {25'h0, target_rate_low});
    acc(1'b1, essc_pkg::OFS_OPT_CAP, 32'hffff_ffff);
    rdchk("opt cap", essc_pkg::OFS_OPT_CAP, 32'h0000_0000);
    acc(1'b1, essc_pkg::OFS_STATUS, 32'hffff_ffff);
    rdchk("status ro", essc_pkg::OFS_STATUS, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  // Four high and three low rate codes, the request bit, and one lane alone.
  task automatic t_rates();
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, essc_pkg::OFS_CONTROL, {17'h0, highs[i], 1'b1, lows[i % 3]});
      rdchk("control", essc_pkg::OFS_CONTROL, {17'h0, highs[i], 1'b0, lows[i % 3]});
      chk("high out", {25'h0, highs[i]}, {25'h0, target_rate_high});
    end
    avs_byteenable <= 4'h2;
    acc(1'b1, essc_pkg::OFS_CONTROL, 32'h0000_0603);
    avs_byteenable <= 4'hf;
    rdchk("lane one", essc_pkg::OFS_CONTROL, 32'h0000_0600);
    $display("test rates done");
  endtask : t_rates

  // Status reports every rate code the link presents.
  task automatic t_status();
    for (int i = 0; i < 7; i++) begin
      negotiated_rate_in <= codes[i];
      repeat (4) @(posedge clk_sys);
      rdchk("rate", essc_pkg::OFS_STATUS, {25'h0, codes[i]});
    end
    negotiated_rate_in <= essc_pkg::RATE_RESET;
    $display("test status done");
  endtask : t_status

  // Calibration waits for low power and L1; done holds until a new request.
  task automatic t_cal();
    acc(1'b1, essc_pkg::OFS_CONTROL, 32'h0000_0080);
    count_start(20);
    chk("early start", 32'h0, npulse);
    link_low_power <= 1'b1;
    link_in_l1     <= 1'b0;
    count_start(20);
    chk("no l1 start", 32'h0, npulse);
    link_in_l1 <= 1'b1;
    count_start(20);
    chk("start", 32'h1, npulse);
    phy_cal_finished <= 1'b1;
    repeat (8) @(posedge clk_sys);
    phy_cal_finished <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdchk("done", essc_pkg::OFS_STATUS, 32'h0000_0080);
    acc(1'b1, essc_pkg::OFS_CONTROL, 32'h0000_0080);
    rdchk("done clr", essc_pkg::OFS_STATUS, 32'h0000_0000);
    link_low_power <= 1'b0;
    $display("test calibration done");
  endtask : t_cal

  // Rates survive nrst only while the compliance flag is set.
  task automatic t_sticky();
    acc(1'b1, essc_pkg::OFS_SUPPORT, 32'h0000_0002);
    acc(1'b1, essc_pkg::OFS_CONTROL, 32'h0000_0a06);
    do_reset(1'b0);
    rdchk("sticky", essc_pkg::OFS_CONTROL, 32'h0000_0a06);
    do_reset(1'b1);
    rdchk("full rst", essc_pkg::OFS_CONTROL, 32'h0000_0000);
    acc(1'b1, essc_pkg::OFS_CONTROL, 32'h0000_0a06);
    do_reset(1'b0);
    rdchk("plain rw", essc_pkg::OFS_CONTROL, 32'h0000_0000);
    $display("test sticky done");
  endtask : t_sticky

  // Bank absent while the strap is clear; an unmapped address is refused.
  task automatic t_absent();
    ext_speed_support_flag <= 1'b0;
    negotiated_rate_in     <= essc_pkg::RATE_8G0;
    repeat (6) @(posedge clk_sys);
    rdchk("absent", essc_pkg::OFS_STATUS, 32'h0000_0000);
    acc(1'b1, essc_pkg::OFS_CONTROL, 32'h0000_0a06);
    ext_speed_support_flag <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rdchk("dropped", essc_pkg::OFS_CONTROL, 32'h0000_0000);
    rdchk("present", essc_pkg::OFS_STATUS, {25'h0, essc_pkg::RATE_8G0});
    acc(1'b0, 4'h1, 32'h0000_0000);
    chk("unmapped", 32'h2, {30'h0, rs});
    $display("test absent done");
  endtask : t_absent

  //////////////////////////////////////////////////////////////////////////////
  // Free-running clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Main sequence: both resets at power up, then every scenario.
  initial begin
    n_mismatch             = 0;
    checks_done            = 0;
    lows                   = '{essc_pkg::RATE_RESET, essc_pkg::RATE_8G0, essc_pkg::RATE_16G0};
    highs                  = '{7'h00, essc_pkg::RATE_16G0, essc_pkg::RATE_20G0,
                               essc_pkg::RATE_25G0};
    codes                  = '{7'h00, essc_pkg::RATE_2G5, essc_pkg::RATE_5G0,
                               essc_pkg::RATE_8G0, essc_pkg::RATE_16G0,
                               essc_pkg::RATE_20G0, essc_pkg::RATE_25G0};
    nrst                   = 1'b0;
    sticky_nrst            = 1'b0;
    avs_address            = 4'h0;
    avs_read               = 1'b0;
    avs_write              = 1'b0;
    avs_writedata          = 32'h0000_0000;
    avs_byteenable         = 4'hf;
    ext_speed_support_flag = 1'b1;
    negotiated_rate_in     = 7'h00;
    link_low_power         = 1'b0;
    link_in_l1             = 1'b1;
    phy_cal_finished       = 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst        <= 1'b1;
    sticky_nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_rates();
    t_status();
    t_cal();
    t_sticky();
    t_absent();
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
